// File: inc/tccs_regs.svh
// Register map, field positions, reset values and timing counts of the timer clock front end.
`ifndef TCCS_REGS_SVH
`define TCCS_REGS_SVH

// =====================================================================
// Register byte offsets
`define TCCS_CTRL1_OFF   8'h00
`define TCCS_STCTRL_OFF  8'h08
`define TCCS_STS_OFF     8'h10
`define TCCS_CNT_OFF     8'h24
`define TCCS_DIV_OFF     8'h28
`define TCCS_PR_OFF      8'h2c

// =====================================================================
// Field positions
`define TCCS_RUN_BIT     0
`define TCCS_PBE_BIT     7
`define TCCS_SMS_LSB     0
`define TCCS_TSS_LSB     4
`define TCCS_OVF_BIT     0
`define TCCS_TRG_BIT     6

// =====================================================================
// Field encodings
`define TCCS_SMS_EXT_A    3'h7
`define TCCS_TSS_CH1_BOTH 3'h4
`define TCCS_TSS_CH1_FILT 3'h5
`define TCCS_TSS_CH2_FILT 3'h6

// =====================================================================
// Reset values and bus answers
`define TCCS_RST16       16'h0000
`define TCCS_RST3        3'h0
`define TCCS_RESP_OKAY   2'h0
`define TCCS_RESP_SLVERR 2'h2

// =====================================================================
// Timing: clock edges from a trigger input change to the count pulse
`define TCCS_EXT_LAT     3

`endif

// File: inc/tccs_pkg.sv
// Types shared by the timer clock front end modules.
package tccs_pkg;

  typedef enum logic {
    TCCS_SRC_INT,
    TCCS_SRC_EXT
  } tccs_src_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic        pulse;
  } tccs_edge_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        aw_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_have;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        run;
    logic        pbe;
    logic [2:0]  sms;
    logic [2:0]  tss;
    logic        ovf_flag;
    logic        trg_flag;
    logic [15:0] div;
    logic [15:0] div_act;
    logic [15:0] pr;
    logic [15:0] pr_act;
    logic [15:0] psc;
    logic [15:0] cnt;
    logic        en;
    logic        ovf_ev;
    logic        trg_ev;
  } tccs_state_t;

endpackage

// File: design/tccs_edge.sv
// Trigger synchroniser and edge-to-pulse converter.
`timescale 1ns/10ps
`default_nettype none

module tccs_edge (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Trigger level and edge choice
  input  wire logic sig,
  input  wire logic both_edges,
  // Single-cycle count pulse
  output logic      pulse
);

  tccs_pkg::tccs_edge_t st_q;
  tccs_pkg::tccs_edge_t st_d;

  // =====================================================================
  // Next state
  // The first stage feeds only the second; edges are judged on s2 and s3.
  always_comb begin
    st_d       = st_q;
    st_d.s1    = sig;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.pulse = both_edges ? (st_q.s2 ^ st_q.s3) : (st_q.s2 & ~st_q.s3);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule

`default_nettype wire

// File: design/tccs_top.sv
// Timer counter clock selection, prescaler and base counter with an AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
`include "tccs_regs.svh"

module tccs_top #(
  parameter bit       TWO_CH       = 1'b1,
  parameter bit [3:0] LINE_PRESENT = 4'hf
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peer and channel trigger sources
  input  wire logic [3:0]  internal_trigger_line,
  input  wire logic        ch1_both_edge_input,
  input  wire logic        ch1_filtered_edge,
  input  wire logic        ch2_filtered_edge,
  // Timer status
  output logic [15:0]      count_value,
  output logic             synced_count_enable,
  output logic             overflow_event,
  output logic             master_trigger_output,
  output logic             trigger_event
);

  tccs_pkg::tccs_state_t st_q;
  tccs_pkg::tccs_state_t st_d;
  tccs_pkg::tccs_src_t   clk_src;
  logic                  slave_trigger_input;
  logic                  edge_pulse;
  logic                  src_tick;
  logic                  count_enable_tick;
  logic                  ovf_now;
  logic                  do_wr;

  // =====================================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == `TCCS_CTRL1_OFF) || (a == `TCCS_STCTRL_OFF) ||
                (a == `TCCS_STS_OFF) || (a == `TCCS_CNT_OFF) ||
                (a == `TCCS_DIV_OFF) || (a == `TCCS_PR_OFF);
  endfunction

  // =====================================================================
  // Clock source selection
  // Channel stages lie outside this block; the variant decides which counting
  // sources exist here and whether trigger_event can fire at all.
  assign clk_src = (st_q.sms == `TCCS_SMS_EXT_A) ? tccs_pkg::TCCS_SRC_EXT
                                                 : tccs_pkg::TCCS_SRC_INT;

  // Lines 0 and 1 come from peer trigger outputs, 2 and 3 from peer compare
  // outputs; a missing peer is masked so its line reads as idle.
  always_comb begin
    slave_trigger_input = 1'b0;
    case (st_q.tss)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        slave_trigger_input = internal_trigger_line[st_q.tss[1:0]] &
                              LINE_PRESENT[st_q.tss[1:0]];
      end
      `TCCS_TSS_CH1_BOTH: begin
        slave_trigger_input = TWO_CH & ch1_both_edge_input;
      end
      `TCCS_TSS_CH1_FILT: begin
        slave_trigger_input = TWO_CH & ch1_filtered_edge;
      end
      `TCCS_TSS_CH2_FILT: begin
        slave_trigger_input = TWO_CH & ch2_filtered_edge;
      end
      default: begin
        slave_trigger_input = 1'b0;
      end
    endcase
  end

  // Selection happens before the synchroniser, so changing the source while
  // running may yield one stray count; change it with the counter stopped.
  tccs_edge u_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sig        (slave_trigger_input),
    .both_edges (st_q.tss == `TCCS_TSS_CH1_BOTH),
    .pulse      (edge_pulse)
  );

  // The internal clock ticks every cycle; the external mode ticks per edge.
  assign src_tick = (clk_src == tccs_pkg::TCCS_SRC_EXT) ? edge_pulse : 1'b1;

  // A period of zero halts the timer.
  assign count_enable_tick = st_q.en && src_tick && (st_q.pr_act != `TCCS_RST16) &&
                             (st_q.psc >= st_q.div_act);
  assign ovf_now           = count_enable_tick && (st_q.cnt >= st_q.pr_act);
  assign do_wr             = st_q.aw_have && st_q.w_have && !st_q.bvalid;

  // =====================================================================
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.ovf_ev = 1'b0;
    st_d.trg_ev = 1'b0;

    // Write channel handshakes; address and data may come in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Counting path.
    st_d.en = st_q.run;
    if (!st_q.pbe) begin
      st_d.pr_act = st_q.pr;
    end
    if (st_q.en && src_tick && (st_q.pr_act != `TCCS_RST16)) begin
      if (count_enable_tick) begin
        st_d.psc = `TCCS_RST16;
        if (ovf_now) begin
          st_d.cnt     = `TCCS_RST16;
          st_d.div_act = st_q.div;
          st_d.pr_act  = st_q.pr;
          st_d.ovf_ev  = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end else begin
        st_d.psc = st_q.psc + 16'h0001;
      end
    end
    if (TWO_CH && edge_pulse) begin
      st_d.trg_ev = 1'b1;
    end

    // Register writes; a counter write overrides the running count.
    if (do_wr) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = reg_known(st_q.awaddr) ? `TCCS_RESP_OKAY : `TCCS_RESP_SLVERR;
      case (st_q.awaddr)
        `TCCS_CTRL1_OFF: begin
          if (st_q.wstrb[0]) begin
            st_d.run = st_q.wdata[`TCCS_RUN_BIT];
            st_d.pbe = st_q.wdata[`TCCS_PBE_BIT];
          end
        end
        `TCCS_STCTRL_OFF: begin
          if (st_q.wstrb[0]) begin
            st_d.sms = st_q.wdata[`TCCS_SMS_LSB +: 3];
            st_d.tss = st_q.wdata[`TCCS_TSS_LSB +: 3];
          end
        end
        `TCCS_STS_OFF: begin
          if (st_q.wstrb[0]) begin
            st_d.ovf_flag = st_q.ovf_flag & ~st_q.wdata[`TCCS_OVF_BIT];
            st_d.trg_flag = st_q.trg_flag & ~st_q.wdata[`TCCS_TRG_BIT];
          end
        end
        `TCCS_CNT_OFF: begin
          st_d.cnt = merge16(st_q.cnt, st_q.wdata, st_q.wstrb);
        end
        `TCCS_DIV_OFF: begin
          st_d.div = merge16(st_q.div, st_q.wdata, st_q.wstrb);
        end
        `TCCS_PR_OFF: begin
          st_d.pr = merge16(st_q.pr, st_q.wdata, st_q.wstrb);
        end
        default: begin
          st_d.bresp = `TCCS_RESP_SLVERR;
        end
      endcase
    end

    // A flag raised in the cycle of its clear stays set.
    if (ovf_now) begin
      st_d.ovf_flag = 1'b1;
    end
    if (st_d.trg_ev) begin
      st_d.trg_flag = 1'b1;
    end

    // Read channel.
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = 32'h0000_0000;
      st_d.rresp  = reg_known(s_axi_araddr) ? `TCCS_RESP_OKAY : `TCCS_RESP_SLVERR;
      case (s_axi_araddr)
        `TCCS_CTRL1_OFF: begin
          st_d.rdata[`TCCS_RUN_BIT] = st_q.run;
          st_d.rdata[`TCCS_PBE_BIT] = st_q.pbe;
        end
        `TCCS_STCTRL_OFF: begin
          st_d.rdata[`TCCS_SMS_LSB +: 3] = st_q.sms;
          st_d.rdata[`TCCS_TSS_LSB +: 3] = st_q.tss;
        end
        `TCCS_STS_OFF: begin
          st_d.rdata[`TCCS_OVF_BIT] = st_q.ovf_flag;
          st_d.rdata[`TCCS_TRG_BIT] = st_q.trg_flag;
        end
        `TCCS_CNT_OFF: begin
          st_d.rdata[15:0] = st_q.cnt;
        end
        `TCCS_DIV_OFF: begin
          st_d.rdata[15:0] = st_q.div;
        end
        `TCCS_PR_OFF: begin
          st_d.rdata[15:0] = st_q.pr;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================================
  // Outputs
  assign s_axi_awready         = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready          = !st_q.w_have && !st_q.bvalid;
  assign s_axi_bvalid          = st_q.bvalid;
  assign s_axi_bresp           = st_q.bresp;
  assign s_axi_arready         = !st_q.rvalid;
  assign s_axi_rvalid          = st_q.rvalid;
  assign s_axi_rdata           = st_q.rdata;
  assign s_axi_rresp           = st_q.rresp;
  assign count_value           = st_q.cnt;
  assign synced_count_enable   = st_q.en;
  assign overflow_event        = st_q.ovf_ev;
  assign master_trigger_output = st_q.ovf_ev;
  assign trigger_event         = st_q.trg_ev;

  // =====================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  run_to_enable_a: assert property ($rose(st_q.run) |=> st_q.en && $past(st_q.run))
    else $error("synced enable did not follow run bit");
  count_up_only_a: assert property (!do_wr && st_q.cnt != st_d.cnt |->
      st_d.cnt == st_q.cnt + 16'h0001 || st_d.cnt == `TCCS_RST16)
    else $error("counter moved other than up by one or wrap");
  stopped_hold_a: assert property (!st_q.en && !do_wr |=> $stable(st_q.cnt))
    else $error("counter moved while disabled");
  ovf_wrap_a: assert property (ovf_now && !do_wr |=> st_q.cnt == `TCCS_RST16
      && st_q.ovf_flag && overflow_event ##1 !overflow_event)
    else $error("overflow did not wrap and flag");
  div_shadow_a: assert property (!ovf_now |=> $stable(st_q.div_act))
    else $error("prescaler ratio changed outside overflow");
  psc_clear_a: assert property (ovf_now |=> st_q.psc == `TCCS_RST16)
    else $error("prescaler not cleared at overflow");
  period_buffer_a: assert property (st_q.pbe && !ovf_now |=> $stable(st_q.pr_act))
    else $error("buffered period changed outside overflow");
  psc_step_a: assert property (st_q.en && src_tick && st_q.pr_act != `TCCS_RST16
      && st_q.psc < st_q.div_act |=> st_q.psc == $past(st_q.psc) + 16'h0001)
    else $error("prescaler did not advance");
  ext_gate_a: assert property (clk_src == tccs_pkg::TCCS_SRC_EXT && !edge_pulse
      && !do_wr |=> $stable(st_q.psc) && $stable(st_q.cnt))
    else $error("counted without a trigger edge");
  absent_line_a: assert property (st_q.tss[2] == 1'b0 &&
      !LINE_PRESENT[st_q.tss[1:0]] |-> !slave_trigger_input)
    else $error("absent trigger line drove the counter");
  single_ch_a: assert property (!TWO_CH && st_q.tss[2] |-> !slave_trigger_input)
    else $error("channel clock used in single channel variant");

  ovf_seen_c: cover property (overflow_event);
  ext_count_c: cover property (clk_src == tccs_pkg::TCCS_SRC_EXT && count_enable_tick);
  run_rise_c: cover property ($rose(synced_count_enable));
  trig_seen_c: cover property (trigger_event && st_q.tss[2]);

endmodule

`default_nettype wire

// File: tb/tccs_peer.sv
// Model of the peer master timers that drive the internal trigger lines.
`timescale 1ns/10ps
`default_nettype none

module tccs_peer (
  // Clock
  input  wire logic aclk,
  // Peer trigger and compare outputs
  output var logic [3:0] lines
);
  initial lines = 4'h0;

  // =====================================================================
  // Pulse generator
  // Each pulse stands for hold cycles, so a slow peer can be modelled as well as a prompt one.
  task automatic fire(input int idx, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      lines[idx] <= 1'b1;
      repeat (hold) @(posedge aclk);
      lines[idx] <= 1'b0;
      repeat (hold) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// File: tb/test_tccs_top.sv
// Self-checking bench for the timer clock front end.
`timescale 1ns/10ps
`default_nettype none
`include "tccs_regs.svh"

module test_tccs_top;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, lines;
  logic [1:0]  bresp, rresp;
  logic [2:0]  ch;
  logic [15:0] cnt;
  logic        run_en, ovf, mtrg, trg_ev;
  int          miscompares, cmp_count, cyc, d0, d1, p, p2, n, trg_n, ev;
  int          ivq[$];
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [7:0]  offs[6] = '{`TCCS_CTRL1_OFF, `TCCS_STCTRL_OFF, `TCCS_STS_OFF,
                           `TCCS_CNT_OFF, `TCCS_DIV_OFF, `TCCS_PR_OFF};

  // Line 3 is left out so that an absent peer can be selected.
  tccs_top #(.TWO_CH(1'b1), .LINE_PRESENT(4'h7)) u_tccs_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .internal_trigger_line(lines), .ch1_both_edge_input(ch[0]),
    .ch1_filtered_edge(ch[1]), .ch2_filtered_edge(ch[2]),
    .count_value(cnt), .synced_count_enable(run_en), .overflow_event(ovf),
    .master_trigger_output(mtrg), .trigger_event(trg_ev));

  tccs_peer u_tccs_peer (.aclk(aclk), .lines(lines));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // =====================================================================
  // Verdict and compares
  task automatic close_out();
    // A result still awaited means a transfer or an overflow never came.
    if (rq.size() + bq.size() + ivq.size() > 0) begin
      miscompares++;
      $display("Error %0t results still awaited", $time);
    end
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t read got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t write response %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t status bit %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_trg(input int e, input int g);
    cmp_count++;
    if (g != e) begin
      miscompares++;
      $display("Error %0t trigger events %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t count value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_iv(input int e, input int g);
    cmp_count++;
    if (g != e) begin
      miscompares++;
      $display("Error %0t overflow spacing %0d expected %0d", $time, g, e);
    end
  endtask

  // =====================================================================
  // Bus master
  // The loop flag is blocking: the handshake signals only change after the
  // edge, so they cannot tell the loop within the same time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic busy;
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic busy;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    busy = 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask

  // =====================================================================
  // Stimulus helpers
  task automatic ovf_wait(input int k);
    while (k > 0) begin
      @(negedge aclk);
      if (ovf === 1'b1) k--;
    end
    @(posedge aclk);
  endtask

  task automatic pulses(input int s, input int cnt_n);
    if (s < 4 || s == 7) begin
      u_tccs_peer.fire((s == 7) ? 0 : s, cnt_n, 2 + $urandom % 3);
    end else begin
      for (int i = 0; i < cnt_n; i++) begin
        @(posedge aclk);
        ch[s-4] <= 1'b1;
        repeat (3) @(posedge aclk);
        ch[s-4] <= 1'b0;
        repeat (3) @(posedge aclk);
      end
    end
  endtask

  // =====================================================================
  // Result monitors
  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) chk_rd(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready && bq.size() > 0) chk_b(bq.pop_front(), bresp);
  end

  // Spacing is counted on the falling edge, where the pulse has settled.
  always @(negedge aclk) begin
    cyc++;
    if (trg_ev === 1'b1) trg_n++;
    if (ovf === 1'b1) begin
      chk_bit(mtrg, 1'b1);
      if (ivq.size() > 0) chk_iv(ivq.pop_front(), cyc);
      cyc = 0;
    end
  end

  initial begin
    #(50 * 30000);
    miscompares++;
    close_out();
  end

  // =====================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h89c21f8e));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, ch} = '0;
    {miscompares, cmp_count, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wstrb <= 4'hf;
    foreach (offs[i]) rd(offs[i], 34'h0);
    wr(8'h3c, 32'h1, `TCCS_RESP_SLVERR);
    rd(8'h3c, {`TCCS_RESP_SLVERR, 32'h0});
    wr(`TCCS_STCTRL_OFF, 32'h7, `TCCS_RESP_OKAY);
    pulses(0, 3);
    repeat (6) @(posedge aclk);
    rd(`TCCS_CNT_OFF, 34'h0);
    wr(`TCCS_PR_OFF, 32'hffff, `TCCS_RESP_OKAY);
    wr(`TCCS_CTRL1_OFF, 32'h1, `TCCS_RESP_OKAY);
    @(negedge aclk);
    chk_bit(run_en, 1'b1);
    // Every trigger source, present, absent and unused, is driven with a few edges; the absent and unused ones count none.
    for (int s = 0; s < 8; s++) begin
      n = 1 + $urandom % 4;
      ev = (s == 3 || s == 7) ? 0 : (s == 4) ? 2 * n : n;
      wr(`TCCS_STCTRL_OFF, 32'h7 | (32'(s) << 4), `TCCS_RESP_OKAY);
      wr(`TCCS_CNT_OFF, 32'h0, `TCCS_RESP_OKAY);
      trg_n = 0;
      pulses(s, n);
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk_trg(ev, trg_n);
      chk_cnt(16'(ev), cnt);
      rd(`TCCS_CNT_OFF, {18'h0, 16'(ev)});
    end
    d0 = 1 + $urandom % 2;
    d1 = 1 + $urandom % 2;
    p = 3 + $urandom % 3;
    p2 = 3 + $urandom % 3;
    wr(`TCCS_STCTRL_OFF, 32'h0, `TCCS_RESP_OKAY);
    wr(`TCCS_DIV_OFF, 32'(d0), `TCCS_RESP_OKAY);
    wr(`TCCS_PR_OFF, 32'(p), `TCCS_RESP_OKAY);
    wr(`TCCS_CNT_OFF, 32'h0, `TCCS_RESP_OKAY);
    ovf_wait(2);
    repeat (2) ivq.push_back((d0 + 1) * (p + 1));
    ovf_wait(2);
    // A prescaler write lands mid-period and waits for the overflow.
    ivq.push_back((d0 + 1) * (p + 1));
    ivq.push_back((d1 + 1) * (p + 1));
    wr(`TCCS_DIV_OFF, 32'(d1), `TCCS_RESP_OKAY);
    ovf_wait(2);
    wr(`TCCS_CTRL1_OFF, 32'h81, `TCCS_RESP_OKAY);
    ovf_wait(1);
    ivq.push_back((d1 + 1) * (p + 1));
    ivq.push_back((d1 + 1) * (p2 + 1));
    wr(`TCCS_PR_OFF, 32'(p2), `TCCS_RESP_OKAY);
    ovf_wait(2);
    wr(`TCCS_CTRL1_OFF, 32'h1, `TCCS_RESP_OKAY);
    ovf_wait(1);
    repeat (2) ivq.push_back((d1 + 1) * (p2 + 3));
    wr(`TCCS_PR_OFF, 32'(p2 + 2), `TCCS_RESP_OKAY);
    ovf_wait(2);
    wr(`TCCS_CTRL1_OFF, 32'h0, `TCCS_RESP_OKAY);
    rd(`TCCS_STS_OFF, {2'h0, 32'h41});
    wr(`TCCS_STS_OFF, 32'h41, `TCCS_RESP_OKAY);
    rd(`TCCS_STS_OFF, 34'h0);
    repeat (4) @(posedge aclk);
    close_out();
  end
endmodule
`default_nettype wire
